// [rtl/risp_slave.sv]
// Device end: slave port with register pointer and byte register space
`timescale 1ns/1ps
`default_nettype none
module risp_slave (
   input  wire logic       sys_clk_i,
   input  wire logic       arst_n_i,
   risp_bus_if.device      bus,
   output logic            busy_o,
   output logic            wr_valid_o,
   output logic [7:0]      wr_addr_o,
   output logic [7:0]      wr_data_o,
   output logic            rd_valid_o,
   output logic [7:0]      rd_addr_o
);
   import risp_pkg::*;

   typedef enum logic [2:0] {
      ST_ADDR,
      ST_PTR,
      ST_WDATA,
      ST_RFIRST,
      ST_RDATA,
      ST_IDLE
   } risp_slv_st_t;

   function automatic logic tog_edge(input logic a, input logic b);
      tog_edge = a ^ b;
   endfunction

   logic         scl_s1_q;
   logic         scl_s2_q;
   logic         scl_s3_q;
   logic         sda_s1_q;
   logic         sda_s2_q;
   logic         sda_s3_q;
   logic         hold_q;
   logic         armed_q;
   logic         start_det;
   logic         stop_det;
   logic         scl_fall;
   logic         link_rst_n;
   risp_slv_st_t st_q;
   logic [3:0]   cnt_q;
   logic [7:0]   rx_q;
   logic [7:0]   tx_q;
   logic         mack_q;
   logic         oe_q;
   logic [7:0]   ptr_q;
   logic [7:0]   mem_q [RISP_DEPTH];
   logic [7:0]   rd_byte;
   logic         addr_hit;
   logic         byte_ack;
   logic         wr_now;
   logic         load_tx;
   logic         wr_tog_q;
   logic         rd_tog_q;
   logic [7:0]   wa_q;
   logic [7:0]   wd_q;
   logic [7:0]   ra_q;
   logic [2:0]   wt_s_q;
   logic [2:0]   rt_s_q;
   logic         wr_valid_q;
   logic         rd_valid_q;
   logic [7:0]   wr_addr_q;
   logic [7:0]   wr_data_q;
   logic [7:0]   rd_addr_q;

   // ---- System-clock side: bus condition watch ----
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_s3_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_s3_q <= 1'b1;
      end else begin
         scl_s1_q <= bus.scl;
         scl_s2_q <= scl_s1_q;
         scl_s3_q <= scl_s2_q;
         sda_s1_q <= bus.sda;
         sda_s2_q <= sda_s1_q;
         sda_s3_q <= sda_s2_q;
      end
   end

   // Data moving while the clock is high is a condition, not a bit
   assign start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
   assign stop_det  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
   assign scl_fall  = scl_s3_q & ~scl_s2_q;

   // The bus clock stands still around conditions, so the link logic is
   // held in reset from here and released once the first low phase of a
   // frame has begun, well ahead of the first data rising edge.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hold_q  <= 1'b1;
         armed_q <= 1'b0;
      end else if (start_det) begin
         hold_q  <= 1'b1;
         armed_q <= 1'b1;
      end else if (stop_det) begin
         hold_q  <= 1'b1;
         armed_q <= 1'b0;
      end else if (armed_q && scl_fall) begin
         hold_q  <= 1'b0;
         armed_q <= 1'b0;
      end
   end

   assign link_rst_n = arst_n_i & ~hold_q;
   assign busy_o     = ~hold_q;

   // ---- Link side: clocked by the bus clock ----
   // Bus data is set up around the clock edges by the protocol, so it is
   // sampled here directly rather than through a synchroniser.
   always_ff @(posedge bus.scl or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rx_q   <= RISP_MEM_RST;
         mack_q <= RISP_NACK;
      end else if (cnt_q == RISP_BIT_ACK) begin
         mack_q <= bus.sda;
      end else begin
         rx_q <= {rx_q[6:0], bus.sda};
      end
   end

   assign addr_hit = (rx_q[7:1] == RISP_DEV_ADDR);
   assign byte_ack = (st_q == ST_ADDR && addr_hit) || (st_q == ST_PTR)
                     || (st_q == ST_WDATA);
   assign wr_now   = (cnt_q == RISP_BIT_LAST) && (st_q == ST_WDATA);
   assign load_tx  = (st_q == ST_RFIRST)
                     || (st_q == ST_RDATA && mack_q == RISP_ACK);
   assign rd_byte  = mem_q[ptr_q];

   // All data line changes happen on the falling clock edge
   always_ff @(negedge bus.scl or negedge link_rst_n) begin
      if (!link_rst_n) begin
         st_q  <= ST_ADDR;
         cnt_q <= RISP_BIT_ZERO;
         oe_q  <= 1'b0;
         tx_q  <= RISP_MEM_RST;
      end else if (cnt_q == RISP_BIT_LAST) begin
         cnt_q <= RISP_BIT_ACK;
         // Releases the line for the master's answer while reading
         oe_q  <= byte_ack;
         case (st_q)
            ST_ADDR: begin
               if (!addr_hit) begin
                  st_q <= ST_IDLE;
               end else if (rx_q[0] == RISP_DIR_RD) begin
                  st_q <= ST_RFIRST;
               end else begin
                  st_q <= ST_PTR;
               end
            end
            ST_PTR: begin
               st_q <= ST_WDATA;
            end
            default: begin
               st_q <= st_q;
            end
         endcase
      end else if (cnt_q == RISP_BIT_ACK) begin
         cnt_q <= RISP_BIT_ZERO;
         if (load_tx) begin
            oe_q <= ~rd_byte[7];
            tx_q <= {rd_byte[6:0], 1'b1};
            st_q <= ST_RDATA;
         end else begin
            oe_q <= 1'b0;
            if (st_q == ST_RDATA) begin
               st_q <= ST_IDLE;
            end
         end
      end else begin
         cnt_q <= cnt_q + RISP_BIT_STEP;
         if (st_q == ST_RDATA) begin
            oe_q <= ~tx_q[7];
            tx_q <= {tx_q[6:0], 1'b1};
         end
      end
   end

   // Pointer survives frames; only the hard reset clears it
   always_ff @(negedge bus.scl or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ptr_q <= RISP_PTR_RST;
      end else if (cnt_q == RISP_BIT_LAST && st_q == ST_PTR) begin
         ptr_q <= rx_q;
      end else if (wr_now) begin
         ptr_q <= ptr_q + RISP_PTR_STEP;
      end else if (cnt_q == RISP_BIT_ACK && load_tx) begin
         ptr_q <= ptr_q + RISP_PTR_STEP;
      end
   end

   always_ff @(negedge bus.scl or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < RISP_DEPTH; i++) begin
            mem_q[i] <= RISP_MEM_RST;
         end
      end else if (wr_now) begin
         mem_q[ptr_q] <= rx_q;
      end
   end

   // Event bundles for the system side: word held, toggle announces it
   always_ff @(negedge bus.scl or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_tog_q <= 1'b0;
         rd_tog_q <= 1'b0;
         wa_q     <= RISP_PTR_RST;
         wd_q     <= RISP_MEM_RST;
         ra_q     <= RISP_PTR_RST;
      end else if (wr_now) begin
         wr_tog_q <= ~wr_tog_q;
         wa_q     <= ptr_q;
         wd_q     <= rx_q;
      end else if (cnt_q == RISP_BIT_ACK && load_tx) begin
         rd_tog_q <= ~rd_tog_q;
         ra_q     <= ptr_q;
      end
   end

   assign bus.sda_s_o  = 1'b0;
   assign bus.sda_s_oe = oe_q;

   // ---- System-clock side: event reports ----
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wt_s_q <= 3'h0;
         rt_s_q <= 3'h0;
      end else begin
         wt_s_q <= {wt_s_q[1:0], wr_tog_q};
         rt_s_q <= {rt_s_q[1:0], rd_tog_q};
      end
   end

   // A byte takes nine bus clocks, so the held words are long stable
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_valid_q <= 1'b0;
         rd_valid_q <= 1'b0;
         wr_addr_q  <= RISP_PTR_RST;
         wr_data_q  <= RISP_MEM_RST;
         rd_addr_q  <= RISP_PTR_RST;
      end else begin
         wr_valid_q <= tog_edge(wt_s_q[1], wt_s_q[2]);
         rd_valid_q <= tog_edge(rt_s_q[1], rt_s_q[2]);
         if (tog_edge(wt_s_q[1], wt_s_q[2])) begin
            wr_addr_q <= wa_q;
            wr_data_q <= wd_q;
         end
         if (tog_edge(rt_s_q[1], rt_s_q[2])) begin
            rd_addr_q <= ra_q;
         end
      end
   end

   assign wr_valid_o = wr_valid_q;
   assign wr_addr_o  = wr_addr_q;
   assign wr_data_o  = wr_data_q;
   assign rd_valid_o = rd_valid_q;
   assign rd_addr_o  = rd_addr_q;
endmodule
`default_nettype wire

// [rtl/risp_pkg.sv]
// Shared constants and types for the RTC serial slave port and its master
// Contract
// - Address byte: seven bits 1101000, then direction
// - Direction zero selects master-to-device write
// - Direction one selects device-to-master read
// - Device acknowledges matching address on ninth clock
// - First written byte loads pointer, acknowledged
// - Any number of data bytes, each acknowledged
// - Pointer advances after each written byte
// - Master ends write with STOP
// - Read starts at current pointer register
// - Pointer keeps value between transfers
// - Master acknowledges all read bytes except last
// - Device sends while master acknowledges
// - Master makes all clocks and conditions
// - START begins transfer, STOP ends it
// - Repeated START begins new address phase
// - Address compared right after eighth bit
// - Device releases data line after final nack
// - Data changes only while clock low
package risp_pkg;
   localparam logic [6:0] RISP_DEV_ADDR = 7'h68;
   localparam logic       RISP_DIR_WR   = 1'b0;
   localparam logic       RISP_DIR_RD   = 1'b1;
   localparam logic       RISP_ACK      = 1'b0;
   localparam logic       RISP_NACK     = 1'b1;
   localparam logic [3:0] RISP_BIT_ZERO = 4'h0;
   localparam logic [3:0] RISP_BIT_STEP = 4'h1;
   localparam logic [3:0] RISP_BIT_LAST = 4'h7;
   localparam logic [3:0] RISP_BIT_ACK  = 4'h8;
   localparam int         RISP_DEPTH    = 256;
   localparam logic [7:0] RISP_PTR_RST  = 8'h00;
   localparam logic [7:0] RISP_PTR_STEP = 8'h01;
   localparam logic [7:0] RISP_MEM_RST  = 8'h00;
   localparam logic [7:0] RISP_RD_PAD   = 8'hFF;
   localparam logic [8:0] RISP_SH_IDLE  = 9'h1FF;
   // Bus clock made by the master from the system clock
   localparam int         RISP_SYS_PERIOD_NS = 5;
   localparam int         RISP_SCL_PERIOD_NS = 2500;
   localparam int         RISP_QTR_CYC =
      RISP_SCL_PERIOD_NS / (4 * RISP_SYS_PERIOD_NS);
   localparam logic [7:0] RISP_QTR_CNT  = 8'(RISP_QTR_CYC - 1);
   localparam logic [7:0] RISP_DIV_ZERO = 8'h00;
   localparam logic [7:0] RISP_DIV_STEP = 8'h01;
   localparam logic [1:0] RISP_Q_SET    = 2'h0;
   localparam logic [1:0] RISP_Q_RISE   = 2'h1;
   localparam logic [1:0] RISP_Q_SAMPLE = 2'h2;
   localparam logic [1:0] RISP_Q_STEP   = 2'h1;
   typedef enum logic [1:0] {
      RISP_CMD_START,
      RISP_CMD_WRITE,
      RISP_CMD_READ,
      RISP_CMD_STOP
   } risp_cmd_t;
endpackage

// [rtl/risp_bus_if.sv]
// Two-wire bus carrier joining the master end and the device end
`timescale 1ns/1ps
`default_nettype none
interface risp_bus_if;
   logic scl_m_o;
   logic scl_m_oe;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_s_o;
   logic sda_s_oe;
   logic scl;
   logic sda;

   // Open-drain wires with pull-ups: any enabled driver wins
   assign scl = scl_m_oe ? scl_m_o : 1'b1;
   assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);

   modport master (
      output scl_m_o,
      output scl_m_oe,
      output sda_m_o,
      output sda_m_oe,
      input  scl,
      input  sda
   );
   modport device (
      output sda_s_o,
      output sda_s_oe,
      input  scl,
      input  sda
   );
endinterface
`default_nettype wire

// [rtl/risp_master.sv]
// Master end: byte-level command engine that makes the bus clock
`timescale 1ns/1ps
`default_nettype none
module risp_master (
   input  wire logic             sys_clk_i,
   input  wire logic             arst_n_i,
   risp_bus_if.master            bus,
   input  wire logic             cmd_valid_i,
   output logic                  cmd_ready_o,
   input  wire risp_pkg::risp_cmd_t cmd_i,
   input  wire logic [7:0]       wdata_i,
   input  wire logic             last_i,
   output logic                  done_o,
   output logic [7:0]            rdata_o,
   output logic                  ack_o
);
   import risp_pkg::*;

   typedef enum logic [1:0] {
      M_IDLE,
      M_START,
      M_BYTE,
      M_STOP
   } risp_mst_st_t;

   risp_mst_st_t st_q;
   logic [7:0]   div_q;
   logic [1:0]   qtr_q;
   logic [3:0]   bit_q;
   logic [8:0]   sh_q;
   logic [8:0]   rx_q;
   logic         scl_oe_q;
   logic         sda_oe_q;
   logic         sda_s1_q;
   logic         sda_s2_q;
   logic         done_q;
   logic [7:0]   rdata_q;
   logic         ack_q;
   logic         tick;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
      end else begin
         sda_s1_q <= bus.sda;
         sda_s2_q <= sda_s1_q;
      end
   end

   // Quarter-period divider: the bus clock only runs inside a command
   assign tick = (div_q == RISP_QTR_CNT);

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_q <= RISP_DIV_ZERO;
      end else if (st_q == M_IDLE || tick) begin
         div_q <= RISP_DIV_ZERO;
      end else begin
         div_q <= div_q + RISP_DIV_STEP;
      end
   end

   // Each step spans four quarters: set data, rise, sample, fall
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_q     <= M_IDLE;
         qtr_q    <= RISP_Q_SET;
         bit_q    <= RISP_BIT_ZERO;
         sh_q     <= RISP_SH_IDLE;
         rx_q     <= RISP_SH_IDLE;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         done_q   <= 1'b0;
         rdata_q  <= RISP_MEM_RST;
         ack_q    <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (st_q)
            M_IDLE: begin
               if (cmd_valid_i) begin
                  qtr_q <= RISP_Q_SET;
                  bit_q <= RISP_BIT_ZERO;
                  case (cmd_i)
                     RISP_CMD_START: st_q <= M_START;
                     RISP_CMD_STOP:  st_q <= M_STOP;
                     RISP_CMD_WRITE: begin
                        sh_q <= {wdata_i, RISP_NACK};
                        st_q <= M_BYTE;
                     end
                     default: begin
                        // Final read byte is answered with a nack
                        sh_q <= {RISP_RD_PAD, last_i};
                        st_q <= M_BYTE;
                     end
                  endcase
               end
            end
            default: begin
               if (tick) begin
                  qtr_q <= qtr_q + RISP_Q_STEP;
                  case (qtr_q)
                     RISP_Q_SET: begin
                        if (st_q == M_START) begin
                           sda_oe_q <= 1'b0;
                        end else if (st_q == M_STOP) begin
                           sda_oe_q <= 1'b1;
                        end else begin
                           sda_oe_q <= ~sh_q[8];
                        end
                     end
                     RISP_Q_RISE: begin
                        scl_oe_q <= 1'b0;
                     end
                     RISP_Q_SAMPLE: begin
                        if (st_q == M_START) begin
                           sda_oe_q <= 1'b1;
                        end else if (st_q == M_STOP) begin
                           sda_oe_q <= 1'b0;
                        end else begin
                           rx_q <= {rx_q[7:0], sda_s2_q};
                           sh_q <= {sh_q[7:0], 1'b1};
                        end
                     end
                     default: begin
                        if (st_q == M_START) begin
                           scl_oe_q <= 1'b1;
                           st_q     <= M_IDLE;
                           done_q   <= 1'b1;
                        end else if (st_q == M_STOP) begin
                           st_q   <= M_IDLE;
                           done_q <= 1'b1;
                        end else begin
                           scl_oe_q <= 1'b1;
                           if (bit_q == RISP_BIT_ACK) begin
                              st_q    <= M_IDLE;
                              done_q  <= 1'b1;
                              rdata_q <= rx_q[8:1];
                              ack_q   <= (rx_q[0] == RISP_ACK);
                           end else begin
                              bit_q <= bit_q + RISP_BIT_STEP;
                           end
                        end
                     end
                  endcase
               end
            end
         endcase
      end
   end

   assign cmd_ready_o  = (st_q == M_IDLE);
   assign done_o       = done_q;
   assign rdata_o      = rdata_q;
   assign ack_o        = ack_q;
   assign bus.scl_m_o  = 1'b0;
   assign bus.scl_m_oe = scl_oe_q;
   assign bus.sda_m_o  = 1'b0;
   assign bus.sda_m_oe = sda_oe_q;
endmodule
`default_nettype wire

// [bench/risp_bus_sva.sv]
// Checker for the two-wire bus between the master end and the device end
`timescale 1ns/1ps
`default_nettype none
module risp_bus_sva
   import risp_pkg::*;
(
   input  wire logic sys_clk_i,
   input  wire logic arst_n_i,
   input  wire logic scl_m_oe,
   input  wire logic sda_m_oe,
   input  wire logic sda_s_oe,
   input  wire logic scl,
   input  wire logic sda
);
   logic       scl_q;
   logic       sda_q;
   logic       nak_q;
   logic [3:0] bit_q;
   logic [7:0] byte_q;
   logic [7:0] sh_q;
   logic [7:0] adr_q;
   logic       rise;
   logic       start;
   logic       stop;
   logic       match;
   logic       rd_ph;
   logic       wr_ph;

   // Bus seen through the system clock; a quarter bit spans many cycles
   assign rise  = scl & ~scl_q;
   assign start = scl & scl_q & sda_q & ~sda;
   assign stop  = scl & scl_q & ~sda_q & sda;
   assign match = (adr_q[7:1] == RISP_DEV_ADDR) && (byte_q != 8'h00);
   assign rd_ph = match && (adr_q[0] == RISP_DIR_RD);
   assign wr_ph = match && (adr_q[0] == RISP_DIR_WR);

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         scl_q <= 1'h1;
         sda_q <= 1'h1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bit_q  <= RISP_BIT_ZERO;
         byte_q <= 8'h00;
      end else if (start) begin
         bit_q  <= RISP_BIT_ZERO;
         byte_q <= 8'h00;
      end else if (rise && bit_q == RISP_BIT_ACK) begin
         bit_q  <= RISP_BIT_ZERO;
         byte_q <= byte_q + 8'h01;
      end else if (rise) begin
         bit_q <= bit_q + RISP_BIT_STEP;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sh_q <= 8'h00;
      end else if (rise && bit_q != RISP_BIT_ACK) begin
         sh_q <= {sh_q[6:0], sda};
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         adr_q <= 8'h00;
      end else if (rise && bit_q == RISP_BIT_ACK && byte_q == 8'h00) begin
         adr_q <= sh_q;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         nak_q <= 1'h0;
      end else if (start) begin
         nak_q <= 1'h0;
      end else if (rise && bit_q == RISP_BIT_ACK && rd_ph && sda) begin
         nak_q <= 1'h1;
      end
   end

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   addr_ack_a: assert property (rise && bit_q == RISP_BIT_ACK &&
      byte_q == 8'h00 && sh_q[7:1] == RISP_DEV_ADDR |-> !sda)
      else $error("matching address not acknowledged");
   addr_nack_a: assert property (rise && bit_q == RISP_BIT_ACK &&
      byte_q == 8'h00 && sh_q[7:1] != RISP_DEV_ADDR |-> sda)
      else $error("foreign address acknowledged");
   foreign_quiet_a: assert property ((byte_q != 8'h00) &&
      (adr_q[7:1] != RISP_DEV_ADDR) |-> !sda_s_oe)
      else $error("device drives after foreign address");
   write_ack_a: assert property (rise && bit_q == RISP_BIT_ACK &&
      wr_ph |-> !sda)
      else $error("written byte not acknowledged");
   // Both scl samples high keeps the ack clock edge itself out
   write_quiet_a: assert property (wr_ph && scl && scl_q &&
      bit_q != RISP_BIT_ZERO |-> !sda_s_oe)
      else $error("device drives data line in write");
   read_quiet_a: assert property (rd_ph && !nak_q && scl && scl_q &&
      bit_q != RISP_BIT_ZERO |-> !sda_m_oe)
      else $error("master drives data line in read");
   nack_release_a: assert property (nak_q |-> !sda_s_oe)
      else $error("data line held after final nack");
   stop_idle_a: assert property (stop |-> !sda_s_oe && !scl_m_oe)
      else $error("bus not released at stop");
   oe_rise_a: assert property ($rose(sda_s_oe) |-> !scl &&
      (bit_q == RISP_BIT_ACK || rd_ph))
      else $error("device drives outside ack or read");
   oe_hold_a: assert property ($changed(sda_s_oe) |-> !scl)
      else $error("device data changed while clock high");

   addr_ack_c: cover property (rise && bit_q == RISP_BIT_ACK &&
      byte_q == 8'h00 && !sda);
   final_nack_c: cover property (nak_q);
   restart_c: cover property (start && byte_q != 8'h00);
endmodule
`default_nettype wire

// [bench/rtc_i2c_slave_port_bench.sv]
// Bench joining master end and device end over the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_slave_port_bench;
   import risp_pkg::*;
   logic       sys_clk   = 1'h0;
   logic       arst_n    = 1'h0;
   logic       cmd_valid = 1'h0;
   risp_cmd_t  cmd       = RISP_CMD_START;
   logic [7:0] wdata     = 8'h00;
   logic       last      = 1'h0;
   logic       cmd_ready;
   logic       done;
   logic [7:0] rdata;
   logic       ack;
   logic       busy;
   logic       wr_valid;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic       rd_valid;
   logic [7:0] rd_addr;
   int         mismatches = 0;
   int         checked    = 0;
   logic [15:0] wq[$];
   logic [7:0]  rq[$];

   always #2.5 sys_clk = ~sys_clk;

   risp_bus_if u_risp_bus_if ();
   risp_master u_risp_master (
      .sys_clk_i(sys_clk), .arst_n_i(arst_n), .bus(u_risp_bus_if.master),
      .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_i(cmd),
      .wdata_i(wdata), .last_i(last), .done_o(done), .rdata_o(rdata),
      .ack_o(ack));
   risp_slave u_risp_slave (
      .sys_clk_i(sys_clk), .arst_n_i(arst_n), .bus(u_risp_bus_if.device),
      .busy_o(busy), .wr_valid_o(wr_valid), .wr_addr_o(wr_addr),
      .wr_data_o(wr_data), .rd_valid_o(rd_valid), .rd_addr_o(rd_addr));
   risp_bus_sva u_risp_bus_sva (
      .sys_clk_i(sys_clk), .arst_n_i(arst_n),
      .scl_m_oe(u_risp_bus_if.scl_m_oe), .sda_m_oe(u_risp_bus_if.sda_m_oe),
      .sda_s_oe(u_risp_bus_if.sda_s_oe), .scl(u_risp_bus_if.scl),
      .sda(u_risp_bus_if.sda));

   // Device reports are collected so each test can judge them afterwards
   always @(posedge sys_clk) begin
      if (wr_valid === 1'h1) wq.push_back({wr_addr, wr_data});
      if (rd_valid === 1'h1) rq.push_back(rd_addr);
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h", $time, what, got);
      end
   endtask

   // Ready is high in idle, so the request is taken one edge after it rises
   task automatic issue(input risp_cmd_t c, input logic [7:0] wd,
                        input logic l);
      int n;
      n = 0;
      @(posedge sys_clk);
      cmd_valid <= 1'h1;
      cmd       <= c;
      wdata     <= wd;
      last      <= l;
      @(posedge sys_clk);
      cmd_valid <= 1'h0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
         if (n == 1) chk({15'h0000, cmd_ready}, 16'h0000, "ready while busy");
      end while (done !== 1'h1 && n < 8000);
      // A hung command ends the run through the normal verdict
      if (n >= 8000) begin
         chk(16'h0000, 16'h0001, "command hung");
         conclude();
      end
      chk({15'h0000, cmd_ready}, 16'h0001, "ready at done");
   endtask

   task automatic wbyte(input logic [7:0] d, input logic a);
      issue(RISP_CMD_WRITE, d, 1'h0);
      chk({15'h0000, ack}, {15'h0000, a}, "write ack");
   endtask

   task automatic rbyte(input logic l, input logic [7:0] e);
      issue(RISP_CMD_READ, 8'hFF, l);
      chk({8'h00, rdata}, {8'h00, e}, "read data");
   endtask

   task automatic test_write();
      wq.delete();
      issue(RISP_CMD_START, 8'h00, 1'h0);
      wbyte(8'hD0, 1'h1);
      chk({15'h0000, busy}, 16'h0001, "busy in frame");
      wbyte(8'h10, 1'h1);
      wbyte(8'hA5, 1'h1);
      wbyte(8'h3C, 1'h1);
      issue(RISP_CMD_STOP, 8'h00, 1'h0);
      chk(16'(wq.size()), 16'h0002, "write count");
      chk(wq[0], 16'h10A5, "first write");
      chk(wq[1], 16'h113C, "second write");
      chk({15'h0000, busy}, 16'h0000, "busy after stop");
      $display("test write done");
   endtask

   task automatic test_restart();
      wq.delete();
      rq.delete();
      issue(RISP_CMD_START, 8'h00, 1'h0);
      wbyte(8'hD0, 1'h1);
      wbyte(8'h10, 1'h1);
      issue(RISP_CMD_START, 8'h00, 1'h0);
      wbyte(8'hD1, 1'h1);
      rbyte(1'h0, 8'hA5);
      rbyte(1'h1, 8'h3C);
      issue(RISP_CMD_STOP, 8'h00, 1'h0);
      chk(16'(wq.size()), 16'h0000, "pointer only, no store");
      chk(16'(rq.size()), 16'h0002, "read count");
      chk({8'h00, rq[0]}, 16'h0010, "first read addr");
      chk({8'h00, rq[1]}, 16'h0011, "second read addr");
      $display("test restart done");
   endtask

   task automatic test_ptr_only();
      rq.delete();
      issue(RISP_CMD_START, 8'h00, 1'h0);
      wbyte(8'hD0, 1'h1);
      wbyte(8'h11, 1'h1);
      issue(RISP_CMD_STOP, 8'h00, 1'h0);
      issue(RISP_CMD_START, 8'h00, 1'h0);
      wbyte(8'hD1, 1'h1);
      rbyte(1'h0, 8'h3C);
      rbyte(1'h1, RISP_MEM_RST);
      issue(RISP_CMD_STOP, 8'h00, 1'h0);
      chk({8'h00, rq[1]}, 16'h0012, "pointer after reads");
      $display("test pointer kept done");
   endtask

   task automatic test_foreign();
      wq.delete();
      rq.delete();
      issue(RISP_CMD_START, 8'h00, 1'h0);
      wbyte(8'hA0, 1'h0);
      wbyte(8'h55, 1'h0);
      issue(RISP_CMD_STOP, 8'h00, 1'h0);
      chk(16'(wq.size()), 16'h0000, "store after foreign");
      issue(RISP_CMD_START, 8'h00, 1'h0);
      wbyte(8'hD1, 1'h1);
      rbyte(1'h1, RISP_MEM_RST);
      issue(RISP_CMD_STOP, 8'h00, 1'h0);
      chk({8'h00, rq[0]}, 16'h0013, "pointer untouched");
      $display("test foreign address done");
   endtask

   task automatic conclude();
      $display("counts: %0d mismatches, %0d checked", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'h1;
      test_write();
      test_restart();
      test_ptr_only();
      test_foreign();
      conclude();
   end

   // About 87600 cycles of traffic; the limit stays under 100000 cycles
   initial begin
      #480000;
      mismatches++;
      $display("unexpected at %0t: watchdog expired", $time);
      conclude();
   end
endmodule
`default_nettype wire
